// File: hw/ssim_flags.sv
// Status flags of the serial core: levels pass, events stick until read.
// Assumes same-clock strobes from the serial core.
module ssim_flags (
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  input  wire logic [7:0]  i_levels,
  input  wire logic [3:0]  i_evt_pulse,
  input  wire logic        i_rx_load,
  input  wire logic        i_rx_data_read,
  input  wire logic        i_status_read,
  output logic      [11:0] o_flags,
  output logic      [4:0]  o_evt_new
);
  logic [4:0] sticky;
  logic [4:0] next_sticky;
  logic       unread;
  logic       next_unread;
  logic [4:0] set_vec;

  always_comb begin
    set_vec = {i_evt_pulse[3:0], i_rx_load & unread & ~i_rx_data_read};
    next_sticky = sticky & ~{5{i_status_read}};
    // overrun on reload; set wins over clear
    next_sticky = next_sticky | set_vec;
    next_unread = unread;
    if (i_rx_data_read) begin
      next_unread = 1'b0;
    end
    if (i_rx_load) begin
      next_unread = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      sticky <= '0;
      unread <= 1'b0;
    end else begin
      sticky <= next_sticky;
      unread <= next_unread;
    end
  end

  assign o_flags   = {sticky[4:1], i_levels[7:6], sticky[0], i_levels[4:0]};
  assign o_evt_new = set_vec;

  AST_OVR_SET: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_rx_load && unread && !i_rx_data_read |=> sticky[0])
    else $error("overrun not flagged");
  AST_RD_CLR: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_status_read && i_evt_pulse == 4'h0 |=> sticky[4:1] == 4'h0)
    else $error("event flags not cleared by read");
endmodule : ssim_flags

// File: hw/ssim_pkg.sv
// Constants for the serial interrupt mask block.
// Assumes one 25 MHz clock and an Avalon-MM register slave.
//
// Contract
// - Enable write one sets end-of-reception mask
// - Enable sets buffer full, compare, sync masks
// - Disable port write-only, ones clear masks
// - Disable low byte maps eight core sources
// - Disable bits 8-11 compare and sync
// - Disable bit 5 clears overrun mask
// - Disable bit 10 clears tx sync mask
// - Mask view read-only, one means enabled
// - Mask view same positions, rx sync bit 11
// - Mask view compare b at bit 9
// - Compare and sync flags clear on read
// - Overrun sets on load before read
package ssim_pkg;
  localparam int          NSRC           = 12;
  localparam int          AW             = 4;
  localparam logic [3:0]  OFS_STATUS     = 4'h0;
  localparam logic [3:0]  OFS_ENABLE     = 4'h1;
  localparam logic [3:0]  OFS_DISABLE    = 4'h2;
  localparam logic [3:0]  OFS_MASK       = 4'h3;
  localparam logic [3:0]  OFS_EVT        = 4'h4;
  localparam logic [3:0]  OFS_EVT_MASK   = 4'h5;
  localparam int          B_TX_HOLD_FREE = 0;
  localparam int          B_TX_ALL_DONE  = 1;
  localparam int          B_TX_DMA_END   = 2;
  localparam int          B_TX_DMA_EMPTY = 3;
  localparam int          B_RX_HOLD_FULL = 4;
  localparam int          B_RX_OVERRUN   = 5;
  localparam int          B_RX_DMA_END   = 6;
  localparam int          B_RX_DMA_FULL  = 7;
  localparam int          B_CMP_A        = 8;
  localparam int          B_CMP_B        = 9;
  localparam int          B_TX_SYNC      = 10;
  localparam int          B_RX_SYNC      = 11;
  localparam logic [11:0] MASK_RESET     = 12'h000;
  localparam logic [11:0] STICKY_BITS    = 12'hf20;
  localparam logic [11:0] EVT_RESET      = 12'h000;
endpackage : ssim_pkg

// File: hw/ssim_top.sv
// Interrupt mask logic of a synchronous serial controller.
// Assumes Avalon-MM master on the same clock and same-clock core flags.
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
module ssim_top (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_srst,
  input  wire logic [ssim_pkg::AW-1:0] i_avs_address,
  input  wire logic                   i_avs_read,
  input  wire logic                   i_avs_write,
  input  wire logic [31:0]            i_avs_writedata,
  input  wire logic [3:0]             i_avs_byteenable,
  output logic      [31:0]            o_avs_readdata,
  output logic                        o_avs_waitrequest,
  input  wire logic [7:0]             i_core_levels,
  input  wire logic [3:0]             i_core_evt,
  input  wire logic                   i_rx_load,
  input  wire logic                   i_rx_data_read,
  output logic                        o_core_irq,
  output logic                        o_evt_irq
);
  logic [11:0] mask;
  logic [11:0] next_mask;
  logic [4:0]  evt;
  logic [4:0]  next_evt;
  logic [4:0]  evt_mask;
  logic [4:0]  next_evt_mask;
  logic [31:0] next_rdata;
  logic        ack;
  logic        next_ack;
  logic        next_irq;
  logic        next_evt_irq;
  logic        next_wreq;
  logic        status_rd;
  logic [11:0] flags;
  logic [4:0]  evt_new;
  logic [11:0] wd;
  logic        wr_en;
  logic        wr_dis;
  logic        acc;

  // One wait state: first cycle stalls, second completes
  assign acc       = (i_avs_read | i_avs_write) & ~ack;
  assign wd        = i_avs_writedata[11:0] & {{4{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  assign wr_en     = i_avs_write & ack & (i_avs_address == ssim_pkg::OFS_ENABLE);
  assign wr_dis    = i_avs_write & ack & (i_avs_address == ssim_pkg::OFS_DISABLE);
  assign status_rd = i_avs_read & acc & (i_avs_address == ssim_pkg::OFS_STATUS);

  ssim_flags ssim_flags_inst (
    .i_core_clk     (i_core_clk),
    .i_srst         (i_srst),
    .i_levels       (i_core_levels),
    .i_evt_pulse    (i_core_evt),
    .i_rx_load      (i_rx_load),
    .i_rx_data_read (i_rx_data_read),
    .i_status_read  (status_rd),
    .o_flags        (flags),
    .o_evt_new      (evt_new)
  );

  always_comb begin
    next_mask = mask;
    if (wr_en) begin
      next_mask = next_mask | wd;
    end
    if (wr_dis) begin
      next_mask = next_mask & ~wd;
    end
    if (i_avs_write && ack && i_avs_address == ssim_pkg::OFS_EVT_MASK) begin
      next_evt_mask = wd[4:0];
    end else begin
      next_evt_mask = evt_mask;
    end
    // Sticky event log, write one clears, set wins
    next_evt = evt;
    if (i_avs_write && ack && i_avs_address == ssim_pkg::OFS_EVT) begin
      next_evt = evt & ~wd[4:0];
    end
    next_evt = next_evt | evt_new;
    next_ack = acc;
    next_wreq = ~acc;
    next_rdata = o_avs_readdata;
    if (acc && i_avs_read) begin
      case (i_avs_address)
        ssim_pkg::OFS_STATUS:   next_rdata = {20'h00000, flags};
        ssim_pkg::OFS_MASK:     next_rdata = {20'h00000, mask};
        ssim_pkg::OFS_EVT:      next_rdata = {27'h0000000, evt};
        ssim_pkg::OFS_EVT_MASK: next_rdata = {27'h0000000, evt_mask};
        default:                next_rdata = 32'h0000_0000;
      endcase
    end
    next_irq     = |(flags & mask);
    next_evt_irq = |(evt & evt_mask);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      mask           <= ssim_pkg::MASK_RESET;
      evt            <= 5'h00;
      evt_mask       <= 5'h00;
      ack            <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
      o_core_irq     <= 1'b0;
      o_evt_irq      <= 1'b0;
    end else begin
      mask           <= next_mask;
      evt            <= next_evt;
      evt_mask       <= next_evt_mask;
      ack            <= next_ack;
      o_avs_waitrequest <= next_wreq;
      o_avs_readdata <= next_rdata;
      o_core_irq     <= next_irq;
      o_evt_irq      <= next_evt_irq;
    end
  end

  AST_EN_SET: assert property (@(posedge i_core_clk) disable iff (i_srst)
    wr_en && !wr_dis |=> (mask & $past(wd)) == $past(wd))
    else $error("enable did not set mask");
  AST_EN_KEEP: assert property (@(posedge i_core_clk) disable iff (i_srst)
    wr_en |=> (mask & ~$past(wd)) == ($past(mask) & ~$past(wd)))
    else $error("enable zero bits changed mask");
  AST_DIS_CLR: assert property (@(posedge i_core_clk) disable iff (i_srst)
    wr_dis |=> (mask & $past(wd)) == 12'h000)
    else $error("disable did not clear mask");
  AST_DIS_KEEP: assert property (@(posedge i_core_clk) disable iff (i_srst)
    wr_dis && !wr_en |=> mask == ($past(mask) & ~$past(wd)))
    else $error("disable zero bits changed mask");
  AST_OVR_OFF: assert property (@(posedge i_core_clk) disable iff (i_srst)
    wr_dis && wd[ssim_pkg::B_RX_OVERRUN] |=> !mask[ssim_pkg::B_RX_OVERRUN])
    else $error("overrun mask not cleared");
  AST_TXS_OFF: assert property (@(posedge i_core_clk) disable iff (i_srst)
    wr_dis && wd[ssim_pkg::B_TX_SYNC] |=> !mask[ssim_pkg::B_TX_SYNC])
    else $error("tx sync mask not cleared");
  AST_MASK_RD: assert property (@(posedge i_core_clk) disable iff (i_srst)
    acc && i_avs_read && i_avs_address == ssim_pkg::OFS_MASK
      |=> o_avs_readdata == {20'h00000, $past(mask)})
    else $error("mask view readback wrong");
  AST_IRQ: assert property (@(posedge i_core_clk) disable iff (i_srst)
    ##1 o_core_irq == |($past(flags) & $past(mask)))
    else $error("irq does not follow flags and mask");
  AST_MASK_HOLD: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !wr_en && !wr_dis |=> mask == $past(mask))
    else $error("mask changed without enable or disable write");
  AST_WAIT: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("slave did not answer in one wait");
  AST_HI_ZERO: assert property (@(posedge i_core_clk) disable iff (i_srst)
    o_avs_readdata[31:12] == 20'h00000)
    else $error("upper bits nonzero");
  AST_CMPB: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !mask[ssim_pkg::B_CMP_B] && flags == 12'h200 |=> !o_core_irq)
    else $error("compare b irq while disabled");

  COV_EN: cover property (@(posedge i_core_clk) wr_en);
  COV_DIS: cover property (@(posedge i_core_clk) wr_dis);
  COV_IRQ: cover property (@(posedge i_core_clk) o_core_irq);
  COV_EVT: cover property (@(posedge i_core_clk) o_evt_irq);
endmodule : ssim_top

// File: verif/ssim_top_test.sv
// Testbench for the serial interrupt mask block.
// Assumes the top module alone, driven over Avalon-MM at 25 MHz.
module ssim_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        srst;
  logic [3:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        wreq;
  logic [7:0]  lvl;
  logic [3:0]  evt;
  logic        rxl;
  logic        rxr;
  logic        irq;
  logic        eirq;
  logic [31:0] q;
  logic [31:0] exp_m;
  int          num_errors;
  int          samples_checked;

  ssim_top ssim_top_inst (
    .i_core_clk(clk), .i_srst(srst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_core_levels(lvl),
    .i_core_evt(evt), .i_rx_load(rxl), .i_rx_data_read(rxr),
    .o_core_irq(irq), .o_evt_irq(eirq)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr   <= w;
    rd   <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    if (n >= 50) num_errors++;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    check(what, q, exp);
  endtask : rdc

  task automatic pulse(input logic [3:0] e, input logic ld, input logic rr);
    @(posedge clk);
    evt <= e;
    rxl <= ld;
    rxr <= rr;
    @(posedge clk);
    evt <= 4'h0;
    rxl <= 1'b0;
    rxr <= 1'b0;
  endtask : pulse

  initial begin
    #400000;
    num_errors++;
    close_out();
  end

  initial begin
    srst = 1'b1; addr = 4'h0; rd = 1'b0; wr = 1'b0; wdat = 32'h0;
    lvl = 8'h00; evt = 4'h0; rxl = 1'b0; rxr = 1'b0; be = 4'hf;
    num_errors = 0; samples_checked = 0; exp_m = 32'h0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rdc(ssim_pkg::OFS_MASK, 32'h0, "mask after reset");
    check("irq after reset", {31'h0, irq}, 32'h0);
    $display("test reset done");
    bus(1'b1, ssim_pkg::OFS_ENABLE, 32'hfffff000);
    rdc(ssim_pkg::OFS_MASK, 32'h0, "enable zeros and upper bits");
    for (int i = 0; i < ssim_pkg::NSRC; i++) begin
      bus(1'b1, ssim_pkg::OFS_ENABLE, 32'h1 << i);
      exp_m |= 32'h1 << i;
      rdc(ssim_pkg::OFS_MASK, exp_m, "mask after enable");
    end
    bus(1'b1, ssim_pkg::OFS_MASK, 32'h0);
    rdc(ssim_pkg::OFS_MASK, 32'hfff, "mask view write ignored");
    rdc(4'hf, 32'h0, "unmapped read");
    bus(1'b1, ssim_pkg::OFS_DISABLE, 32'hfffff000);
    rdc(ssim_pkg::OFS_MASK, 32'hfff, "disable zeros and upper bits");
    for (int i = 0; i < ssim_pkg::NSRC; i++) begin
      bus(1'b1, ssim_pkg::OFS_DISABLE, 32'h1 << i);
      exp_m &= ~(32'h1 << i);
      rdc(ssim_pkg::OFS_MASK, exp_m, "mask after disable");
    end
    be <= 4'h1;
    bus(1'b1, ssim_pkg::OFS_ENABLE, 32'hfff);
    be <= 4'hf;
    rdc(ssim_pkg::OFS_MASK, 32'hff, "enable low byte only");
    bus(1'b1, ssim_pkg::OFS_DISABLE, 32'hfff);
    rdc(ssim_pkg::OFS_MASK, 32'h0, "disable all");
    $display("test mask ports done");
    bus(1'b1, ssim_pkg::OFS_ENABLE, 32'h1);
    lvl <= 8'h01;
    repeat (3) @(posedge clk);
    check("irq level unmasked", {31'h0, irq}, 32'h1);
    bus(1'b1, ssim_pkg::OFS_DISABLE, 32'h1);
    repeat (3) @(posedge clk);
    check("irq level masked", {31'h0, irq}, 32'h0);
    lvl <= 8'h00;
    bus(1'b1, ssim_pkg::OFS_ENABLE, 32'h20);
    pulse(4'h0, 1'b1, 1'b0);
    pulse(4'h0, 1'b0, 1'b1);
    pulse(4'h0, 1'b1, 1'b0);
    rdc(ssim_pkg::OFS_STATUS, 32'h0, "no overrun after read");
    pulse(4'h0, 1'b1, 1'b0);
    repeat (3) @(posedge clk);
    check("irq overrun", {31'h0, irq}, 32'h1);
    bus(1'b1, ssim_pkg::OFS_DISABLE, 32'h20);
    repeat (3) @(posedge clk);
    check("irq overrun masked", {31'h0, irq}, 32'h0);
    rdc(ssim_pkg::OFS_STATUS, 32'h20, "overrun flag");
    rdc(ssim_pkg::OFS_STATUS, 32'h0, "overrun cleared");
    for (int k = 0; k < 4; k++) begin
      pulse(4'h1 << k, 1'b0, 1'b0);
      rdc(ssim_pkg::OFS_STATUS, 32'h100 << k, "event flag set");
      rdc(ssim_pkg::OFS_STATUS, 32'h0, "event flag cleared");
    end
    $display("test flags done");
    bus(1'b1, ssim_pkg::OFS_EVT_MASK, 32'h0);
    pulse(4'h1, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    check("event irq masked", {31'h0, eirq}, 32'h0);
    bus(1'b1, ssim_pkg::OFS_EVT_MASK, 32'h1f);
    repeat (3) @(posedge clk);
    check("event irq raised", {31'h0, eirq}, 32'h1);
    rdc(ssim_pkg::OFS_EVT, 32'h1f, "event log");
    rdc(ssim_pkg::OFS_EVT_MASK, 32'h1f, "event mask view");
    bus(1'b1, ssim_pkg::OFS_EVT, 32'h1f);
    repeat (3) @(posedge clk);
    check("event irq cleared", {31'h0, eirq}, 32'h0);
    rdc(ssim_pkg::OFS_EVT, 32'h0, "event log cleared");
    $display("test event irq done");
    close_out();
  end
endmodule : ssim_top_test
